// [rtl/sxa_alu.sv]
// Our own choices: the address map and the APB register port.
`default_nettype none

// Behaviour
// (RULE_01) Accumulator minus operand minus carry, into accumulator.
// (RULE_02) Carry set on borrow out of bit 7.
// (RULE_03) Half-borrow set on borrow out of bit 3.
// (RULE_04) Signed-range set when borrows into 6/7 differ.
// (RULE_05) Subtract source: register, direct, pointer, immediate.
// (RULE_06) Nibble swap of accumulator, flags untouched.
// (RULE_07) Exchange accumulator with register, direct or pointer.
// (RULE_08) Swap low nibbles with pointed RAM byte.
// (RULE_09) Exclusive-OR into destination, no flag changes.
// (RULE_10) Accumulator destination: four source forms, one cycle.
// (RULE_11) Direct destination: accumulator or immediate, immediate two cycles.
// (RULE_12) Port read-modify-write uses latch, not pins.
// (RULE_13) Three bits pick bank register, one bit pointer.
module sxa_alu #(
  parameter logic [7:0] PORT_ADDR = 8'h90, // Direct address of the output port latch.
  parameter int unsigned RAM_DEPTH = 256   // Internal RAM bytes reached indirectly.
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_byte2,
  input wire logic [7:0] instr_byte3,
  output logic instr_done,
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_latch_out,
  output logic carry_flag,
  output logic half_borrow_flag,
  output logic signed_range_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Internal RAM; bank registers live in its lowest 32 bytes. It has no reset.
  logic [7:0] ram_q [RAM_DEPTH];
  logic [7:0] acc_q;       // Accumulator.
  logic [1:0] bank_q;      // Selected register bank.
  logic [7:0] port_q;      // Output port latch.
  logic badop_q;           // Sticky unknown-opcode indication.
  logic done_q;            // One-cycle completion pulse.
  sxa_pkg::sxa_state_e state_q;
  logic [7:0] wb_addr_q;   // Destination held for the second cycle.
  logic [7:0] wb_mask_q;   // Immediate mask held for the second cycle.

  // Flags are kept as separate bits so each has its own clear and set logic.
  logic cy_q;
  logic hb_q;
  logic sr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Classifies an opcode; used for execution and for the error flag.
  function automatic sxa_pkg::sxa_op_e op_class(input logic [7:0] op);
    sxa_pkg::sxa_op_e cls;
    cls = sxa_pkg::SXA_OP_NONE;
    if ((op & sxa_pkg::OPM_REG) == sxa_pkg::OPC_SUB_REG || op == sxa_pkg::OPC_SUB_DIR ||
        (op & sxa_pkg::OPM_PTR) == sxa_pkg::OPC_SUB_PTR || op == sxa_pkg::OPC_SUB_IMM) begin
      cls = sxa_pkg::SXA_OP_SUB; // [RULE_05]
    end else if (op == sxa_pkg::OPC_NIB_SWAP) begin
      cls = sxa_pkg::SXA_OP_SWAP;
    end else if ((op & sxa_pkg::OPM_REG) == sxa_pkg::OPC_XCH_REG ||
                 op == sxa_pkg::OPC_XCH_DIR ||
                 (op & sxa_pkg::OPM_PTR) == sxa_pkg::OPC_XCH_PTR) begin
      cls = sxa_pkg::SXA_OP_XCH;
    end else if ((op & sxa_pkg::OPM_PTR) == sxa_pkg::OPC_LOW_NIBBLE_EXCHANGE_PTR) begin
      cls = sxa_pkg::SXA_OP_LOW_NIBBLE_EXCHANGE;
    end else if ((op & sxa_pkg::OPM_REG) == sxa_pkg::OPC_XOR_REG ||
                 (op & sxa_pkg::OPM_PTR) == sxa_pkg::OPC_XOR_PTR ||
                 op == sxa_pkg::OPC_XOR_DIR || op == sxa_pkg::OPC_XOR_IMM) begin
      cls = sxa_pkg::SXA_OP_XOR_A; // [RULE_10]
    end else if (op == sxa_pkg::OPC_XOR_DIR_A) begin
      cls = sxa_pkg::SXA_OP_XOR_DA; // [RULE_11]
    end else if (op == sxa_pkg::OPC_XOR_DIR_IMM) begin
      cls = sxa_pkg::SXA_OP_XOR_DI; // [RULE_11]
    end
    return cls;
  endfunction

  // Addressing mode of the accumulator-side operand, read from the low opcode bits.
  function automatic sxa_pkg::sxa_mode_e op_mode(input logic [7:0] op);
    sxa_pkg::sxa_mode_e md;
    if (op[3]) begin
      md = sxa_pkg::SXA_AM_REG;
    end else if (op[2:1] == 2'b11) begin
      md = sxa_pkg::SXA_AM_PTR;
    end else if (op[0]) begin
      md = sxa_pkg::SXA_AM_DIR;
    end else begin
      md = sxa_pkg::SXA_AM_IMM;
    end
    return md;
  endfunction

  // RAM address of a bank register in the current bank.
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] sel);
    return {3'b000, bank, sel}; // [RULE_13]
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Operand fetch.

  sxa_pkg::sxa_op_e cls;
  sxa_pkg::sxa_mode_e mode;
  logic fire;            // An instruction is accepted this cycle.
  logic [7:0] opnd_addr; // Address of the memory operand.
  logic opnd_sfr;        // Operand sits in special register space.
  logic [7:0] opnd_val;  // Operand value as a plain read sees it.
  logic [7:0] ptr_val;   // RAM address held in the selected pointer register.

  assign cls = op_class(instr_opcode);
  assign mode = op_mode(instr_opcode);
  assign instr_ready = ce && (state_q == sxa_pkg::SXA_ST_IDLE);
  assign fire = instr_valid && instr_ready;

  // The pointer bit picks register 0 or 1 of the current bank.
  assign ptr_val = ram_q[bank_addr(bank_q, {2'b00, instr_opcode[0]})]; // [RULE_13]

  // Works out where the operand lives; immediate data needs no address.
  always_comb begin
    opnd_sfr = 1'b0;
    case (mode)
      sxa_pkg::SXA_AM_REG: begin
        opnd_addr = bank_addr(bank_q, instr_opcode[2:0]); // [RULE_13]
      end
      sxa_pkg::SXA_AM_PTR: begin
        opnd_addr = ptr_val;
      end
      sxa_pkg::SXA_AM_DIR: begin
        opnd_addr = instr_byte2;
        opnd_sfr = (instr_byte2 >= sxa_pkg::SFR_BASE);
      end
      default: begin
        opnd_addr = instr_byte2;
      end
    endcase
  end

  // A plain read of the port returns the pin levels; other special registers read 0.
  always_comb begin
    if (mode == sxa_pkg::SXA_AM_IMM) begin
      opnd_val = instr_byte2;
    end else if (!opnd_sfr) begin
      opnd_val = ram_q[opnd_addr];
    end else if (opnd_addr == PORT_ADDR) begin
      opnd_val = port_pins_in;
    end else begin
      opnd_val = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Subtract with borrow.

  // Separate narrow differences expose the borrows out of bits 3, 6 and 7.
  logic [8:0] sub_full;
  logic [4:0] sub_low4;
  logic [7:0] sub_low7;

  assign sub_full = {1'b0, acc_q} - {1'b0, opnd_val} - {8'h00, cy_q}; // [RULE_01]
  assign sub_low4 = {1'b0, acc_q[3:0]} - {1'b0, opnd_val[3:0]} - {4'h0, cy_q};
  assign sub_low7 = {1'b0, acc_q[6:0]} - {1'b0, opnd_val[6:0]} - {7'h00, cy_q};

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state datapath.

  logic [7:0] acc_d;
  logic cy_d;
  logic hb_d;
  logic sr_d;
  logic mem_we;        // Write the memory operand back.
  logic [7:0] mem_addr;
  logic mem_sfr;
  logic [7:0] mem_wdata;
  logic [7:0] latch_view; // Value of a direct byte as read-modify-write sees it.

  // Read-modify-write of the port must see what was written, not the pins,
  // or a pin held low by a load would be flipped into the latch by mistake.
  always_comb begin
    if (state_q == sxa_pkg::SXA_ST_WB) begin
      if (wb_addr_q < sxa_pkg::SFR_BASE) begin
        latch_view = ram_q[wb_addr_q];
      end else if (wb_addr_q == PORT_ADDR) begin
        latch_view = port_q; // [RULE_12]
      end else begin
        latch_view = 8'h00;
      end
    end else if (instr_byte2 < sxa_pkg::SFR_BASE) begin
      latch_view = ram_q[instr_byte2];
    end else if (instr_byte2 == PORT_ADDR) begin
      latch_view = port_q; // [RULE_12]
    end else begin
      latch_view = 8'h00;
    end
  end

  // One case covers the first cycle of every operation; flags change only for the subtract.
  always_comb begin
    acc_d = acc_q;
    cy_d = cy_q;
    hb_d = hb_q;
    sr_d = sr_q;
    mem_we = 1'b0;
    mem_addr = opnd_addr;
    mem_sfr = opnd_sfr;
    mem_wdata = acc_q;
    if (state_q == sxa_pkg::SXA_ST_WB) begin
      // Second cycle of the three-byte form: write the masked byte back.
      mem_we = ce;
      mem_addr = wb_addr_q;
      mem_sfr = (wb_addr_q >= sxa_pkg::SFR_BASE);
      mem_wdata = latch_view ^ wb_mask_q; // [RULE_09] [RULE_11]
    end else if (fire) begin
      case (cls)
        sxa_pkg::SXA_OP_SUB: begin
          acc_d = sub_full[7:0]; // [RULE_01]
          cy_d = sub_full[8]; // [RULE_02]
          hb_d = sub_low4[4]; // [RULE_03]
          sr_d = sub_low7[7] ^ sub_full[8]; // [RULE_04]
        end
        sxa_pkg::SXA_OP_SWAP: begin
          acc_d = {acc_q[3:0], acc_q[7:4]}; // [RULE_06]
        end
        sxa_pkg::SXA_OP_XCH: begin
          acc_d = opnd_val; // [RULE_07]
          mem_we = 1'b1;
          mem_wdata = acc_q; // [RULE_07]
        end
        sxa_pkg::SXA_OP_LOW_NIBBLE_EXCHANGE: begin
          acc_d = {acc_q[7:4], opnd_val[3:0]}; // [RULE_08]
          mem_we = 1'b1;
          mem_wdata = {opnd_val[7:4], acc_q[3:0]}; // [RULE_08]
        end
        sxa_pkg::SXA_OP_XOR_A: begin
          acc_d = acc_q ^ opnd_val; // [RULE_09] [RULE_10]
        end
        sxa_pkg::SXA_OP_XOR_DA: begin
          mem_we = 1'b1;
          mem_addr = instr_byte2;
          mem_sfr = (instr_byte2 >= sxa_pkg::SFR_BASE);
          mem_wdata = latch_view ^ acc_q; // [RULE_09] [RULE_11] [RULE_12]
        end
        default: begin
          // Unknown opcodes and the two-cycle form change nothing here.
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  logic bus_busy;
  logic bus_hit;
  logic bus_wr;

  // The bus waits while an instruction runs, so a software write never races
  // a datapath write to the same register.
  assign bus_busy = instr_valid || (state_q != sxa_pkg::SXA_ST_IDLE);
  assign pready = ce && !bus_busy;
  assign bus_hit = (paddr == sxa_pkg::OFS_ACC) || (paddr == sxa_pkg::OFS_FLAGS) ||
                   (paddr == sxa_pkg::OFS_PORT) || (paddr == sxa_pkg::OFS_STATUS);
  assign pslverr = psel && penable && !bus_hit;
  assign bus_wr = psel && penable && pready && pwrite;

  // Read data is captured in the setup cycle and held through the access phase.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        sxa_pkg::OFS_ACC: prdata <= {24'h00_0000, acc_q};
        sxa_pkg::OFS_FLAGS: prdata <= {27'h000_0000, bank_q, sr_q, hb_q, cy_q};
        sxa_pkg::OFS_PORT: prdata <= {24'h00_0000, port_q};
        sxa_pkg::OFS_STATUS: prdata <= {30'h0000_0000, badop_q,
                                        state_q == sxa_pkg::SXA_ST_WB};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State updates.

  // Accumulator: software write or datapath result.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= sxa_pkg::ACC_RST;
    end else if (ce) begin
      if (bus_wr && paddr == sxa_pkg::OFS_ACC) begin
        acc_q <= pwdata[7:0];
      end else begin
        acc_q <= acc_d;
      end
    end
  end

  // Flags and bank select.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {sr_q, hb_q, cy_q} <= sxa_pkg::FLAGS_RST;
      bank_q <= sxa_pkg::BANK_RST;
    end else if (ce) begin
      if (bus_wr && paddr == sxa_pkg::OFS_FLAGS) begin
        cy_q <= pwdata[sxa_pkg::FLG_CY];
        hb_q <= pwdata[sxa_pkg::FLG_HB];
        sr_q <= pwdata[sxa_pkg::FLG_SR];
        bank_q <= pwdata[sxa_pkg::FLG_BANK_LSB +: 2];
      end else begin
        cy_q <= cy_d;
        hb_q <= hb_d;
        sr_q <= sr_d;
      end
    end
  end

  // Internal RAM write port; direct addresses in special space never land here.
  always_ff @(posedge core_clk) begin
    if (ce && mem_we && !mem_sfr) begin
      ram_q[mem_addr] <= mem_wdata;
    end
  end

  // Output port latch: software write or a direct write to its address.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_q <= sxa_pkg::PORT_RST;
    end else if (ce) begin
      if (bus_wr && paddr == sxa_pkg::OFS_PORT) begin
        port_q <= pwdata[7:0];
      end else if (mem_we && mem_sfr && mem_addr == PORT_ADDR) begin
        port_q <= mem_wdata; // [RULE_12]
      end
    end
  end

  // Sequencer: only the three-byte exclusive-OR takes a second cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= sxa_pkg::SXA_ST_IDLE;
      wb_addr_q <= 8'h00;
      wb_mask_q <= 8'h00;
      done_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        sxa_pkg::SXA_ST_IDLE: begin
          done_q <= fire && cls != sxa_pkg::SXA_OP_XOR_DI;
          if (fire && cls == sxa_pkg::SXA_OP_XOR_DI) begin
            state_q <= sxa_pkg::SXA_ST_WB; // [RULE_11]
            wb_addr_q <= instr_byte2;
            wb_mask_q <= instr_byte3;
          end
        end
        sxa_pkg::SXA_ST_WB: begin
          state_q <= sxa_pkg::SXA_ST_IDLE;
          done_q <= 1'b1;
        end
        default: begin
          state_q <= sxa_pkg::SXA_ST_IDLE;
          done_q <= 1'b0;
        end
      endcase
    end
  end

  // Sticky error: a new bad opcode wins over a software clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      badop_q <= 1'b0;
    end else if (ce) begin
      if (fire && cls == sxa_pkg::SXA_OP_NONE) begin
        badop_q <= 1'b1;
      end else if (bus_wr && paddr == sxa_pkg::OFS_STATUS && pwdata[sxa_pkg::STS_BADOP]) begin
        badop_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign instr_done = done_q;
  assign port_latch_out = port_q;
  assign carry_flag = cy_q;
  assign half_borrow_flag = hb_q;
  assign signed_range_flag = sr_q;

endmodule

`default_nettype wire

// [rtl/sxa_pkg.sv]
`default_nettype none

// Shared constants and types for the subtract, exclusive-OR and exchange datapath.
package sxa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register window offsets (byte addresses on the register bus).
  localparam logic [11:0] OFS_ACC = 12'h000;    // Accumulator, read and write.
  localparam logic [11:0] OFS_FLAGS = 12'h004;  // Flags and bank select, read and write.
  localparam logic [11:0] OFS_PORT = 12'h008;   // Output port latch, read and write.
  localparam logic [11:0] OFS_STATUS = 12'h00C; // Busy and opcode error; writing 1 to the error bit clears it.

  // Field positions inside the flags register.
  localparam int unsigned FLG_CY = 0;       // Carry (borrow) flag.
  localparam int unsigned FLG_HB = 1;       // Half-borrow flag.
  localparam int unsigned FLG_SR = 2;       // Signed-range flag.
  localparam int unsigned FLG_BANK_LSB = 3; // Two-bit register bank select.

  // Field positions inside the status register.
  localparam int unsigned STS_BUSY = 0;    // An instruction is in its second cycle.
  localparam int unsigned STS_BADOP = 1;   // Sticky: an unknown opcode was offered.

  // Values after reset.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [7:0] PORT_RST = 8'hFF;

  // Direct space: addresses at or above this are special registers, below it is RAM.
  localparam logic [7:0] SFR_BASE = 8'h80;

  // Opcode masks: register forms carry three select bits, pointer forms one.
  localparam logic [7:0] OPM_REG = 8'hF8;
  localparam logic [7:0] OPM_PTR = 8'hFE;

  // Opcode patterns.
  localparam logic [7:0] OPC_SUB_REG = 8'h98;
  localparam logic [7:0] OPC_SUB_DIR = 8'h95;
  localparam logic [7:0] OPC_SUB_PTR = 8'h96;
  localparam logic [7:0] OPC_SUB_IMM = 8'h94;
  localparam logic [7:0] OPC_NIB_SWAP = 8'hC4;
  localparam logic [7:0] OPC_XCH_REG = 8'hC8;
  localparam logic [7:0] OPC_XCH_DIR = 8'hC5;
  localparam logic [7:0] OPC_XCH_PTR = 8'hC6;
  localparam logic [7:0] OPC_LOW_NIBBLE_EXCHANGE_PTR = 8'hD6;
  localparam logic [7:0] OPC_XOR_REG = 8'h68;
  localparam logic [7:0] OPC_XOR_PTR = 8'h66;
  localparam logic [7:0] OPC_XOR_DIR = 8'h65;
  localparam logic [7:0] OPC_XOR_IMM = 8'h64;
  localparam logic [7:0] OPC_XOR_DIR_A = 8'h62;
  localparam logic [7:0] OPC_XOR_DIR_IMM = 8'h63;

  // Operation classes.
  typedef enum logic [2:0] {
    SXA_OP_NONE = 3'b000,
    SXA_OP_SUB = 3'b001,
    SXA_OP_SWAP = 3'b010,
    SXA_OP_XCH = 3'b011,
    SXA_OP_LOW_NIBBLE_EXCHANGE = 3'b100,
    SXA_OP_XOR_A = 3'b101,
    SXA_OP_XOR_DA = 3'b110,
    SXA_OP_XOR_DI = 3'b111
  } sxa_op_e;

  // Operand addressing modes.
  typedef enum logic [1:0] {
    SXA_AM_REG = 2'b00,
    SXA_AM_DIR = 2'b01,
    SXA_AM_PTR = 2'b10,
    SXA_AM_IMM = 2'b11
  } sxa_mode_e;

  // Sequencer states.
  typedef enum logic [0:0] {
    SXA_ST_IDLE = 1'b0,
    SXA_ST_WB = 1'b1
  } sxa_state_e;

endpackage

`default_nettype wire

// [tb/sxa_alu_chk.sv]
`default_nettype none

// Watches the datapath's handshakes, flags and port latch from its ports.
module sxa_alu_chk #(
  parameter logic [7:0] PORT_ADDR = 8'h90 // Direct address of the port latch.
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_byte3,
  input wire logic [7:0] instr_byte2,
  input wire logic instr_done,
  input wire logic [7:0] port_latch_out,
  input wire logic carry_flag,
  input wire logic half_borrow_flag,
  input wire logic signed_range_flag
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // An instruction is taken when offered and accepted on the same edge.
  logic take;
  logic dir_imm; // The two-cycle exclusive-OR into a direct byte.
  logic flag_free; // Opcodes that must leave every flag alone.
  assign take = instr_valid && instr_ready;
  assign dir_imm = instr_opcode == 8'h63;
  assign flag_free = (instr_opcode inside {8'hC4, 8'hC5, 8'hD6, 8'hD7, 8'h62, 8'h63, 8'h64,
    8'h65, 8'h66, 8'h67, 8'hC6, 8'hC7}) || ((instr_opcode & 8'hF8) inside {8'hC8, 8'h68});

  ////////////////////////////////////////////////////////////////////////////////
  AST_DONE_ONE: assert property (take && !dir_imm |=> instr_done)
    else $error("one-cycle instruction gave no done pulse");
  AST_DIR_IMM_TWO: assert property (take && dir_imm |=>
    !instr_ready && !pready && !instr_done ##1 instr_done && instr_ready)
    else $error("two-cycle instruction timing wrong");
  AST_NO_STRAY_DONE: assert property (instr_done |->
    $past(take && !dir_imm) || $past(take && dir_imm, 2))
    else $error("done pulse without a taken instruction");
  AST_FLAGS_KEPT: assert property (take && flag_free |=>
    {carry_flag, half_borrow_flag, signed_range_flag} ==
    $past({carry_flag, half_borrow_flag, signed_range_flag}))
    else $error("flags changed by a flag-free instruction");
  AST_PORT_LATCH_XOR: assert property (take && dir_imm && instr_byte2 == PORT_ADDR |=>
    ##1 port_latch_out == ($past(port_latch_out, 2) ^ $past(instr_byte3, 2)))
    else $error("port latch not updated from latch value");
  AST_PORT_UNTOUCHED: assert property (take && instr_opcode inside {8'h62, 8'h63} &&
    instr_byte2 != PORT_ADDR |=> ##1 port_latch_out == $past(port_latch_out, 2))
    else $error("port latch changed by another destination");
  AST_BUS_HELD: assert property (instr_valid |-> !pready)
    else $error("bus answered while an instruction was offered");
  AST_BAD_ADDR: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("slave error does not match the address map");
endmodule

bind sxa_alu sxa_alu_chk #(.PORT_ADDR(PORT_ADDR)) chk_u (.core_clk, .rst_n, .psel, .penable,
  .paddr, .pready, .pslverr, .instr_valid, .instr_ready, .instr_opcode, .instr_byte3,
  .instr_byte2, .instr_done, .port_latch_out, .carry_flag, .half_borrow_flag,
  .signed_range_flag);

`default_nettype wire

// [tb/sxa_tb_core.sv]
`default_nettype none

// Stand-in for the instruction sequencer and for the pins of the output port.
module sxa_tb_core (
  input wire logic core_clk,
  input wire logic instr_ready,
  input wire logic [7:0] port_latch_out,
  output logic instr_valid,
  output logic [7:0] instr_opcode,
  output logic [7:0] instr_byte2,
  output logic [7:0] instr_byte3,
  output logic [7:0] port_pins_in
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins are pulled against the latch, so a read of pins instead of latch shows up.
  assign port_pins_in = ~port_latch_out;

  // Nothing is offered before the first task call.
  initial begin
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_byte2 = 8'h00;
    instr_byte3 = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Offers one instruction and holds it until the edge that takes it.
  task automatic issue(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    instr_byte2 <= b2;
    instr_byte3 <= b3;
    @(posedge core_clk);
    while (instr_ready !== 1'b1) @(posedge core_clk);
    // Released bytes show their inverse, so stale values are never trusted.
    instr_valid <= 1'b0;
    instr_opcode <= ~op;
    instr_byte2 <= ~b2;
    instr_byte3 <= ~b3;
  endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none

// Self-checking bench: register setup over the bus, a table of cases, then edge cases.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // One case: state written first, instruction, then the state it should leave.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flg;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] eacc;
    logic [7:0] eflg;
  } sxa_tb_row_s;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instr_valid;
  logic instr_ready;
  logic [7:0] instr_opcode;
  logic [7:0] instr_byte2;
  logic [7:0] instr_byte3;
  logic instr_done;
  logic [7:0] port_pins_in;
  logic [7:0] port_latch_out;
  logic carry_flag;
  logic half_borrow_flag;
  logic signed_range_flag;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rdat;
  logic rerr;
  // Setup entries {acc, opcode, byte2}: RAM 20h=54h, R0=20h, R1=21h, RAM 21h=0Fh, R2=54h.
  logic [23:0] setup [5] = '{24'h54_C520, 24'h20_C800, 24'h21_C900, 24'h0F_C521, 24'h54_CA00};
  // Ordinary cases; flags byte is bit0 carry, bit1 half-borrow, bit2 signed-range.
  sxa_tb_row_s rows [11] = '{
    48'hC9_01_9A_00_74_04, 48'h00_00_94_01_FF_03, 48'h80_00_94_01_7F_06,
    48'h10_01_95_20_BB_03, 48'h50_00_97_00_41_02, 48'h00_18_94_00_00_18,
    48'hC5_07_C4_00_5C_07, 48'hC3_05_68_00_E3_05, 48'hC3_00_64_AA_69_00,
    48'h0F_02_65_20_5B_02, 48'hF0_00_67_00_FF_00};

  always #25 core_clk = ~core_clk;

  sxa_alu dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_opcode(instr_opcode), .instr_byte2(instr_byte2), .instr_byte3(instr_byte3),
    .instr_done(instr_done), .port_pins_in(port_pins_in), .port_latch_out(port_latch_out),
    .carry_flag(carry_flag), .half_borrow_flag(half_borrow_flag),
    .signed_range_flag(signed_range_flag));

  sxa_tb_core seq_u (.core_clk(core_clk), .instr_ready(instr_ready),
    .port_latch_out(port_latch_out), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_byte2(instr_byte2), .instr_byte3(instr_byte3), .port_pins_in(port_pins_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One bus transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it with the expected byte.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdat, {24'h00_0000, exp});
  endtask

  // Loads the accumulator and runs one instruction on it.
  task automatic run(input logic [7:0] acc, input logic [7:0] op, input logic [7:0] b2,
                     input logic [7:0] b3);
    apb(1'b1, 12'h000, {24'h00_0000, acc});
    seq_u.issue(op, b2, b3);
  endtask

  // A hang is cut short and counted as a mismatch.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values and the unmapped address.
    rd_chk(12'h000, 8'h00);
    rd_chk(12'h004, 8'h00);
    rd_chk(12'h008, 8'hFF);
    rd_chk(12'h00C, 8'h00);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    // RAM has no reset, so registers and bytes are seeded by exchanges first.
    foreach (setup[i]) run(setup[i][23:16], setup[i][15:8], setup[i][7:0], 8'h00);
    foreach (rows[i]) begin
      apb(1'b1, 12'h004, {24'h00_0000, rows[i].flg});
      run(rows[i].acc, rows[i].op, rows[i].b2, 8'h00);
      rd_chk(12'h000, rows[i].eacc);
      rd_chk(12'h004, rows[i].eflg);
    end
    // Exchange both ways with R2.
    run(8'h11, 8'hCA, 8'h00, 8'h00);
    rd_chk(12'h000, 8'h54);
    seq_u.issue(8'hCA, 8'h00, 8'h00);
    rd_chk(12'h000, 8'h11);
    // Low-nibble exchange through R0 with RAM 20h holding 54h.
    apb(1'b1, 12'h004, 32'h0000_0005);
    run(8'h36, 8'hD6, 8'h00, 8'h00);
    rd_chk(12'h000, 8'h34);
    rd_chk(12'h004, 8'h05);
    run(8'h00, 8'hC5, 8'h20, 8'h00);
    rd_chk(12'h000, 8'h56);
    // Port read-modify-write must start from the latch, pins show the inverse.
    run(8'h0F, 8'h62, 8'h90, 8'h00);
    rd_chk(12'h008, 8'hF0);
    seq_u.issue(8'h63, 8'h90, 8'h31);
    rd_chk(12'h008, 8'hC1);
    check({24'h00_0000, port_latch_out}, 32'h0000_00C1);
    // Direct RAM byte as destination, then read back by exchange.
    seq_u.issue(8'h62, 8'h20, 8'h00);
    seq_u.issue(8'h63, 8'h20, 8'hA0);
    run(8'h00, 8'hC5, 8'h20, 8'h00);
    rd_chk(12'h000, 8'hAF);
    // Unknown opcode leaves the accumulator and sets the sticky status bit.
    run(8'h3C, 8'hA5, 8'h00, 8'h00);
    rd_chk(12'h000, 8'h3C);
    rd_chk(12'h00C, 8'h02);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    rd_chk(12'h00C, 8'h00);
    // A second reset in mid-run restores the reset values.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(12'h000, 8'h00);
    rd_chk(12'h008, 8'hFF);
    complete_run();
  end
endmodule

`default_nettype wire
